// File: rtl/dus_pkg.sv
// Constants and carrier types for the sweep, update, sync and power-down control block.
// Assumes a 125 MHz core clock and a 32-bit AHB-Lite register port.
package dus_pkg;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL1 = 8'h00;
  localparam logic [7:0] A_CTRL2 = 8'h04;
  localparam logic [7:0] A_LTW = 8'h08;
  localparam logic [7:0] A_UTW = 8'h0c;
  localparam logic [7:0] A_RDW = 8'h10;
  localparam logic [7:0] A_FDW = 8'h14;
  localparam logic [7:0] A_RATE = 8'h18;
  localparam logic [7:0] A_FREQ = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;

  // Field positions in control_function_one.
  localparam int B_NO_DWELL = 2;
  localparam int B_PD_FULL = 3;
  localparam int B_PD_CLKIN = 4;
  localparam int B_PD_DAC = 5;
  localparam int B_PD_COMP = 6;
  localparam int B_PD_DIG = 7;
  localparam int B_RELOAD_UPD = 15;
  localparam int B_SWEEP_EN = 21;
  localparam int B_SOFT_SYNC = 22;
  localparam int B_AUTO_SYNC = 23;

  // Field positions in control_function_two.
  localparam int B_XTAL_EN = 9;
  localparam int B_HW_SYNC = 10;
  localparam int B_HS_SYNC = 11;

  // Ramp rate register: rising word low half, falling word high half.
  localparam int RATE_W = 16;
  localparam int RATE_FALL_LSB = 16;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Sync clock: core clock divided by four, rising as the phase leaves SYNC_RISE_PHASE.
  localparam int SYNC_DIV = 4;
  localparam logic [1:0] SYNC_RISE_PHASE = 2'h1;
  // Phase at which a synchronised rising edge of the alignment input is seen when in step.
  localparam logic [1:0] ALIGN_PHASE = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic digital;
    logic comp;
    logic dac;
    logic clkin;
  } dus_pd_t;

  typedef struct packed {
    logic [31:0] ctrl1;
    logic [31:0] ctrl2;
    logic [31:0] ltw;
    logic [31:0] utw;
    logic [31:0] rdw;
    logic [31:0] fdw;
    logic [31:0] rate;
  } dus_cfg_t;

endpackage : dus_pkg

// File: rtl/dus_ctrl.sv
// Sweep timing, register transfer, sync clock alignment and power-down decode.
// Assumes an AHB-Lite master on hclk and asynchronous pins for strobe, direction,
// alignment and external power-down.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns

module dus_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sweep_direction_input,
  input wire logic transfer_strobe_input,
  input wire logic align_input,
  input wire logic external_powerdown_pin,
  output logic sync_clk_out,
  output logic update_pulse,
  output logic [31:0] freq_word,
  output dus_pkg::dus_pd_t pd,
  output logic crystal_out_en
);

  typedef struct packed {
    dus_pkg::dus_cfg_t bufr;
    dus_pkg::dus_cfg_t act;
    logic [1:0] phase;
    logic sync_clk;
    logic [2:0] dir_s;
    logic [2:0] upd_s;
    logic [2:0] aln_s;
    logic [2:0] pdp_s;
    logic dir;
    logic upd;
    logic aln;
    logic pdp;
    logic dir_d;
    logic aln_d;
    logic upd_smp;
    logic upd_pulse;
    logic sweep_en_d;
    logic soft_sync_d;
    logic [dus_pkg::RATE_W-1:0] timer;
    logic [31:0] freq;
    logic running;
    dus_pkg::dus_pd_t pd;
    logic xtal_en;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } dus_state_t;

  dus_state_t r;
  dus_state_t next_r;

  // Ramp rate word for the given direction: falling when low, rising when high.
  function automatic logic [dus_pkg::RATE_W-1:0] rate_for(input logic up,
                                                          input logic [31:0] rate);
    logic [dus_pkg::RATE_W-1:0] w;
    w = up ? rate[dus_pkg::RATE_W-1:0]
           : rate[dus_pkg::RATE_FALL_LSB +: dus_pkg::RATE_W];
    rate_for = w;
  endfunction : rate_for

  logic tick;
  logic advance;
  logic aln_rise;
  logic dir_rise;
  logic dir_fall;
  logic sweep_en;
  logic no_dwell;
  logic step_up;
  logic [32:0] sum;
  logic [32:0] diff;
  logic [1:0] step_inc;

  always_comb begin
    next_r = r;
    sum = 33'h0_0000_0000;
    diff = 33'h0_0000_0000;
    step_up = 1'b0;

    // Three-stage pin synchronisers; a level counts once stages two and three agree.
    next_r.dir_s = {r.dir_s[1:0], sweep_direction_input};
    next_r.upd_s = {r.upd_s[1:0], transfer_strobe_input};
    next_r.aln_s = {r.aln_s[1:0], align_input};
    next_r.pdp_s = {r.pdp_s[1:0], external_powerdown_pin};
    if (r.dir_s[1] == r.dir_s[2]) begin
      next_r.dir = r.dir_s[2];
    end
    if (r.upd_s[1] == r.upd_s[2]) begin
      next_r.upd = r.upd_s[2];
    end
    if (r.aln_s[1] == r.aln_s[2]) begin
      next_r.aln = r.aln_s[2];
    end
    if (r.pdp_s[1] == r.pdp_s[2]) begin
      next_r.pdp = r.pdp_s[2];
    end
    next_r.dir_d = r.dir;
    next_r.aln_d = r.aln;

    // Sync clock divider and phase alignment.
    tick = (r.phase == dus_pkg::SYNC_RISE_PHASE);
    aln_rise = r.aln & ~r.aln_d;
    next_r.soft_sync_d = r.act.ctrl1[dus_pkg::B_SOFT_SYNC];
    advance = 1'b0;
    if (r.act.ctrl1[dus_pkg::B_SOFT_SYNC] && !r.soft_sync_d) begin
      advance = 1'b1;
    end
    if (r.act.ctrl2[dus_pkg::B_HW_SYNC] && aln_rise) begin
      advance = 1'b1;
    end
    if (r.act.ctrl1[dus_pkg::B_AUTO_SYNC] && aln_rise && r.phase != dus_pkg::ALIGN_PHASE) begin
      advance = 1'b1;
    end
    // Skipping one phase count moves the next rising edge one core cycle earlier.
    step_inc = advance ? 2'h2 : 2'h1;
    next_r.phase = r.phase + step_inc;
    next_r.sync_clk = next_r.phase[1];

    // Strobe sampled at each sync clock rising edge except one made by an advance from phase 0; its rising edge makes one pulse.
    next_r.upd_pulse = 1'b0;
    if (tick) begin
      next_r.upd_smp = r.upd;
      next_r.upd_pulse = r.upd & ~r.upd_smp;
    end
    if (r.upd_pulse) begin
      next_r.act = r.bufr;
    end

    // Power-down decode.
    if (!r.pdp) begin
      next_r.pd.digital = r.act.ctrl1[dus_pkg::B_PD_DIG];
      next_r.pd.comp = r.act.ctrl1[dus_pkg::B_PD_COMP];
      next_r.pd.dac = r.act.ctrl1[dus_pkg::B_PD_DAC];
      next_r.pd.clkin = r.act.ctrl1[dus_pkg::B_PD_CLKIN];
    end else if (!r.act.ctrl1[dus_pkg::B_PD_FULL]) begin
      next_r.pd.digital = 1'b1;
      next_r.pd.comp = r.act.ctrl1[dus_pkg::B_PD_COMP];
      next_r.pd.dac = 1'b0;
      next_r.pd.clkin = 1'b0;
    end else begin
      next_r.pd = 4'hf;
    end
    next_r.xtal_en = r.act.ctrl2[dus_pkg::B_XTAL_EN];

    // Linear sweep control.
    sweep_en = r.act.ctrl1[dus_pkg::B_SWEEP_EN];
    no_dwell = r.act.ctrl1[dus_pkg::B_NO_DWELL];
    dir_rise = r.dir & ~r.dir_d;
    dir_fall = ~r.dir & r.dir_d;
    next_r.sweep_en_d = sweep_en;
    if (!sweep_en) begin
      next_r.freq = r.act.ltw;
      next_r.running = 1'b0;
    end else if (dir_rise) begin
      next_r.timer = rate_for(1'b1, r.act.rate);
      next_r.running = 1'b1;
    end else if (dir_fall && !no_dwell) begin
      next_r.timer = rate_for(1'b0, r.act.rate);
    end else if (!r.sweep_en_d) begin
      next_r.timer = rate_for(r.dir, r.act.rate);
      next_r.freq = r.act.ltw;
      next_r.running = r.dir;
    end else if (r.upd_pulse && r.act.ctrl1[dus_pkg::B_RELOAD_UPD]) begin
      next_r.timer = rate_for(r.dir, r.act.rate);
    end else if (tick) begin
      // A falling direction input in no-dwell mode is ignored here.
      step_up = no_dwell ? 1'b1 : r.dir;
      if (r.timer > {{(dus_pkg::RATE_W-1){1'b0}}, 1'b1}) begin
        next_r.timer = r.timer - 1'b1;
      end else begin
        next_r.timer = rate_for(step_up, r.act.rate);
        if (step_up && (r.running || !no_dwell)) begin
          sum = {1'b0, r.freq} + {1'b0, r.act.rdw};
          if (sum >= {1'b0, r.act.utw}) begin
            if (no_dwell) begin
              next_r.freq = r.act.ltw;
              next_r.running = 1'b0;
            end else begin
              next_r.freq = r.act.utw;
            end
          end else begin
            next_r.freq = sum[31:0];
          end
        end else if (!step_up) begin
          diff = {1'b0, r.freq} - {1'b0, r.act.fdw};
          if (diff[32] || diff[31:0] <= r.act.ltw) begin
            next_r.freq = r.act.ltw;
          end else begin
            next_r.freq = diff[31:0];
          end
        end
      end
    end

    // Bus data phase: a write lands in the buffered registers only.
    if (r.dp_wr) begin
      case (r.dp_addr)
        dus_pkg::A_CTRL1: next_r.bufr.ctrl1 = hwdata;
        dus_pkg::A_CTRL2: next_r.bufr.ctrl2 = hwdata;
        dus_pkg::A_LTW: next_r.bufr.ltw = hwdata;
        dus_pkg::A_UTW: next_r.bufr.utw = hwdata;
        dus_pkg::A_RDW: next_r.bufr.rdw = hwdata;
        dus_pkg::A_FDW: next_r.bufr.fdw = hwdata;
        dus_pkg::A_RATE: next_r.bufr.rate = hwdata;
        default: next_r.bufr = r.bufr;
      endcase
    end

    // Bus address phase: read data is prepared so it stands from a flop in the data phase.
    next_r.dp_wr = 1'b0;
    if (hsel && hready && htrans == dus_pkg::HTRANS_NONSEQ) begin
      next_r.dp_wr = hwrite;
      next_r.dp_addr = haddr[7:0];
      case (haddr[7:0])
        dus_pkg::A_CTRL1: next_r.rdata = r.bufr.ctrl1;
        dus_pkg::A_CTRL2: next_r.rdata = r.bufr.ctrl2;
        dus_pkg::A_LTW: next_r.rdata = r.bufr.ltw;
        dus_pkg::A_UTW: next_r.rdata = r.bufr.utw;
        dus_pkg::A_RDW: next_r.rdata = r.bufr.rdw;
        dus_pkg::A_FDW: next_r.rdata = r.bufr.fdw;
        dus_pkg::A_RATE: next_r.rdata = r.bufr.rate;
        dus_pkg::A_FREQ: next_r.rdata = r.freq;
        dus_pkg::A_STAT: next_r.rdata = {r.timer, 4'h0, r.pd, r.running, r.dir,
                                         r.pdp, r.upd, r.aln, r.sync_clk, r.phase};
        default: next_r.rdata = dus_pkg::RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Zero-wait slave; writes to unmapped offsets are dropped and reads return zero.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign sync_clk_out = r.sync_clk;
  assign update_pulse = r.upd_pulse;
  assign freq_word = r.freq;
  assign pd = r.pd;
  assign crystal_out_en = r.xtal_en;

endmodule : dus_ctrl

// File: verif/dus_ctrl_checker.sv
// Port checker for the sweep, update, sync and power-down control block.
// Assumes one hclk domain and the asynchronous active-low hresetn.
`timescale 1ns/1ns
module dus_ctrl_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic transfer_strobe_input,
  input wire logic external_powerdown_pin,
  input wire logic sync_clk_out,
  input wire logic update_pulse,
  input wire dus_pkg::dus_pd_t pd
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] since_hi;
  logic [3:0] quiet;
  // Ages saturate so that a long idle spell never wraps into a false match.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_hi <= 4'hf;
      quiet <= 4'h0;
    end else begin
      since_hi <= transfer_strobe_input ? 4'h0 : since_hi + {3'h0, since_hi != 4'hf};
      quiet <= (update_pulse || $changed(external_powerdown_pin)) ? 4'h0 :
        quiet + {3'h0, quiet != 4'hf};
    end
  end
  // A phase advance may cut one high cycle, so only the upper bound of two is fixed.
  sequence s_high_two;
    $rose(sync_clk_out) ##1 sync_clk_out;
  endsequence
  sequence s_pin_held;
    external_powerdown_pin [*6];
  endsequence
  a_high_two: assert property ($rose(sync_clk_out) |-> ##[1:2] !sync_clk_out)
    else $error("sync clock high time wrong");
  a_high_max: assert property (s_high_two |=> !sync_clk_out)
    else $error("sync clock high longer than two cycles");
  a_low_short: assert property ($fell(sync_clk_out) |-> ##[1:2] $rose(sync_clk_out))
    else $error("sync clock low time too long");
  a_pulse_single: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse longer than one cycle");
  a_pulse_cause: assert property (update_pulse |-> since_hi <= 4'h9)
    else $error("update pulse without strobe");
  a_pin_digital: assert property (s_pin_held |-> pd.digital)
    else $error("digital power-down not forced");
  a_pin_pair: assert property (s_pin_held |-> pd.dac == pd.clkin && (!pd.dac || pd.comp))
    else $error("external power-down decode wrong");
  a_pd_quiet: assert property (quiet > 4'h8 |-> $stable(pd))
    else $error("power-down changed without cause");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready okay");
endmodule : dus_ctrl_checker
bind dus_ctrl dus_ctrl_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .transfer_strobe_input(transfer_strobe_input),
  .external_powerdown_pin(external_powerdown_pin), .sync_clk_out(sync_clk_out),
  .update_pulse(update_pulse), .pd(pd));

// File: verif/dus_partner.sv
// Controller model: issues transfer strobes and drives the alignment input.
// Assumes it shares hclk with the block, as aligned devices share one clock.
`timescale 1ns/1ns
module dus_partner (
  input wire logic hclk,
  input wire logic go,
  input wire logic master,
  output logic strobe,
  output logic align
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] div = 2'h2;
  // A request in the low tail is dropped, so the low time never falls under one sync period.
  always @(posedge hclk) begin
    if (go && cnt == 4'h0) cnt <= 4'hc;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    div <= div + 2'h1;
  end
  assign strobe = cnt > 4'h8;
  assign align = master & div[1];
endmodule : dus_partner

// File: verif/dus_ctrl_test.sv
// Self-checking bench for dus_ctrl with the controller model on its pins.
// Assumes a lone AHB-Lite slave, so hready is its own hreadyout.
`timescale 1ns/1ns
module dus_ctrl_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rdp = 1'b0;
  logic dir = 1'b0;
  logic pdpin = 1'b0;
  logic go = 1'b0;
  logic master = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, strobe, align, sync_clk_out, update_pulse, crystal_out_en;
  logic [31:0] hrdata, freq_word, r;
  logic [31:0] fmax = 32'h0;
  logic [3:0] e;
  dus_pkg::dus_pd_t pd;
  logic [31:0] q[$];
  int err_total = 0;
  int total_checks = 0;
  always #4 hclk = ~hclk;
  dus_partner u_ptn (.hclk(hclk), .go(go), .master(master), .strobe(strobe), .align(align));
  dus_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sweep_direction_input(dir),
    .transfer_strobe_input(strobe), .align_input(align), .external_powerdown_pin(pdpin),
    .sync_clk_out(sync_clk_out), .update_pulse(update_pulse), .freq_word(freq_word),
    .pd(pd), .crystal_out_en(crystal_out_en));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= dus_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0;
    rdp <= !w;
    if (!w) q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdp <= 1'b0;
  endtask : xfer
  task automatic upd();
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do @(posedge hclk); while (update_pulse !== 1'b1);
    // Long enough for the controller model to finish its low tail before the next call.
    repeat (8) @(posedge hclk);
  endtask : upd
  task automatic align_edge();
    do @(posedge hclk); while (align !== 1'b0);
    do @(posedge hclk); while (align !== 1'b1);
  endtask : align_edge
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // The monitor owns the read compare so that back-to-back reads pair in order.
  always @(posedge hclk) begin
    if (rdp && hreadyout) chk("hrdata", hrdata, q.pop_front());
    if (freq_word > fmax) fmax <= freq_word;
  end
  initial begin
    #160000;
    err_total++;
    close_out();
  end
  initial begin
    r = $urandom(22);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, dus_pkg::A_CTRL1, dus_pkg::RESET_WORD);
    xfer(0, 8'h24, 32'h0);
    r = $urandom();
    xfer(1, dus_pkg::A_UTW, r);
    xfer(0, dus_pkg::A_UTW, r);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom();
      r[3] = i[1];
      pdpin <= i[0];
      xfer(1, dus_pkg::A_CTRL1, {24'h0, r[7:3], 3'h0});
      xfer(1, dus_pkg::A_CTRL2, {22'h0, r[9], 9'h0});
      upd();
      e = !i[0] ? r[7:4] : r[3] ? 4'hf : {1'b1, r[6], 2'h0};
      chk("pd", {28'h0, pd}, {28'h0, e});
      chk("crystal", {31'h0, crystal_out_en}, {31'h0, r[9]});
    end
    pdpin <= 1'b0;
    $display("test power-down done");
    xfer(1, dus_pkg::A_LTW, 32'h100);
    xfer(1, dus_pkg::A_UTW, 32'h130);
    xfer(1, dus_pkg::A_RDW, 32'h10);
    xfer(1, dus_pkg::A_FDW, 32'h10);
    xfer(1, dus_pkg::A_RATE, 32'h0003_0002);
    for (int m = 0; m < 2; m++) begin
      xfer(1, dus_pkg::A_CTRL1, 32'h0);
      upd();
      xfer(1, dus_pkg::A_CTRL1, m == 0 ? 32'h0020_0004 : 32'h0020_0000);
      upd();
      chk("start", freq_word, 32'h100);
      @(negedge hclk) fmax = 32'h0;
      @(posedge hclk) dir <= 1'b1;
      repeat (12) @(posedge hclk);
      // Dropping direction mid-sweep must not stop a no-dwell ramp.
      dir <= m != 0;
      repeat (150) @(posedge hclk);
      // No-dwell returns to the lower word in place of showing the upper one.
      chk("top", fmax, m == 0 ? 32'h120 : 32'h130);
      chk("end", freq_word, m == 0 ? 32'h100 : 32'h130);
      dir <= 1'b0;
      repeat (150) @(posedge hclk);
      chk("down", freq_word, 32'h100);
    end
    $display("test sweep done");
    master <= 1'b1;
    xfer(1, dus_pkg::A_CTRL2, 32'h0000_0c00);
    upd();
    xfer(1, dus_pkg::A_CTRL2, 32'h0000_0800);
    xfer(1, dus_pkg::A_CTRL1, 32'h0080_0000);
    upd();
    repeat (40) @(posedge hclk);
    align_edge();
    chk("auto high", {31'h0, sync_clk_out}, 32'h1);
    @(posedge hclk);
    chk("auto low", {31'h0, sync_clk_out}, 32'h0);
    xfer(1, dus_pkg::A_CTRL1, 32'h0040_0000);
    upd();
    align_edge();
    chk("soft low", {31'h0, sync_clk_out}, 32'h0);
    repeat (2) @(posedge hclk);
    chk("soft high", {31'h0, sync_clk_out}, 32'h1);
    $display("test sync done");
    close_out();
  end
endmodule : dus_ctrl_test
